// [verilog/vts_fuse_fail.sv]
// Decided for this implementation: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
// Operation
// - compute negative-sequence voltage and current from line voltages and phase currents
// - neg-seq voltage above limit with neg-seq current below limit alarms after delay
// - with breaker source: breaker closed, pos current high, pos voltage under 1%
// - without breaker source: pos voltage under 1% and pos current high alarms
// - neg-seq voltage limit 0.0 to 200.0 percent, default 34.6
// - neg-seq current limit 0.0 to 200.0 percent, default 100.0
// - pos-seq current limit 0 to 200 percent, default 100
// - limits in 0.1 percent steps; comparisons within one percent unit
// - delay default 0.10 s, up to 600 s in 0.02 s steps, minimum 0.04 s
// - expired delay accurate to one percent or 30 ms
// - picked-up comparison releases only past 3 percent hysteresis, none on the fixed 1% pos voltage limit
// - alarm rise gives an event when rise event enable set, default on
// - alarm fall gives an event when fall event enable set, default on
// - breaker source from digital inputs or object states; none disables qualification
// - each alarm records real time and all four sequence magnitudes
// - live sequence magnitudes readable as percent of nominal
// - alarm offered as blocking signal for voltage-dependent protection
// - alarm clears within 60 ms after the fault condition goes
module vts_fuse_fail import vts_pkg::*; #(
    parameter int unsigned MS_CYC = MS_CYCLES,
    parameter int unsigned N_DI   = 8,
    parameter int unsigned N_OBJ  = 8
) (
    input  wire logic               clk_sys,
    input  wire logic               rst_n,
    input  wire logic               ce,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic                    hreadyout,
    output logic                    hresp,
    output logic      [31:0]        hrdata,
    input  wire logic               meas_valid,
    input  wire logic signed [15:0] uab_re,
    input  wire logic signed [15:0] uab_im,
    input  wire logic signed [15:0] ubc_re,
    input  wire logic signed [15:0] ubc_im,
    input  wire logic signed [15:0] uca_re,
    input  wire logic signed [15:0] uca_im,
    input  wire logic signed [15:0] ia_re,
    input  wire logic signed [15:0] ia_im,
    input  wire logic signed [15:0] ib_re,
    input  wire logic signed [15:0] ib_im,
    input  wire logic signed [15:0] ic_re,
    input  wire logic signed [15:0] ic_im,
    input  wire logic [47:0]        rtc_time,
    input  wire logic [N_DI-1:0]    di_pins,
    input  wire logic [N_OBJ-1:0]   obj_closed,
    output logic                    alarm,
    output logic                    neg_alarm,
    output logic                    pos_alarm,
    output logic                    volt_prot_block,
    output logic                    evt_alarm_on,
    output logic                    evt_alarm_off
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic                  on_en;
        logic                  off_en;
        logic [4:0]            src;
        logic [10:0]           lim_nsv;
        logic [10:0]           lim_nsc;
        logic [10:0]           lim_psc;
        logic [14:0]           dly;
        logic                  wr_pend;
        logic                  rd_mem;
        logic [7:0]            wa;
        logic [31:0]           rdata;
        logic [N_DI-1:0]       di_s1;
        logic [N_DI-1:0]       di_s2;
        logic [3:0][33:0]      sq;
        logic [3:0][15:0]      mag;
        logic [3:0]            pick;
        logic [15:0]           ms_cnt;
        logic                  ms_tick;
        vts_tmr_e [1:0]        tst;
        logic [1:0][19:0]      tcnt;
        logic                  alarm;
        logic                  ev_on;
        logic                  ev_off;
        logic                  on_seen;
        logic                  off_seen;
    } vts_state_s;

    vts_state_s st_r;
    vts_state_s st_nxt;

    logic        rec_we;
    logic [31:0] mem_q;
    logic [1:0]  cond;
    logic        brk_closed;

    // ****************************************
    // sequence arithmetic
    // ****************************************
    // rotation by a (s=1) or a squared (s=-1), a = -1/2 + j*0.866
    function automatic int rot_re(input int x, input int y, input int s);
        rot_re = -(x >>> 1) - s * ((ROT_K * y) >>> ROT_SHIFT);
    endfunction : rot_re
    function automatic int rot_im(input int x, input int y, input int s);
        rot_im = s * ((ROT_K * x) >>> ROT_SHIFT) - (y >>> 1);
    endfunction : rot_im
    // sequence phasor squared magnitude; neg selects the negative sequence
    function automatic logic [33:0] seq_sq(input int x0, input int y0, input int x1, input int y1,
                                           input int x2, input int y2, input logic neg);
        int     s;
        int     sre;
        int     sim;
        longint p;
        s   = neg ? -1 : 1;
        sre = (x0 + rot_re(x1, y1, s) + rot_re(x2, y2, -s)) / 3;
        sim = (y0 + rot_im(x1, y1, s) + rot_im(x2, y2, -s)) / 3;
        p   = longint'(sre) * sre + longint'(sim) * sim;
        seq_sq = p[33:0];
    endfunction : seq_sq

    // display magnitude by bit-serial root search: exact, at the cost of a long compare chain
    function automatic logic [15:0] isqrt(input logic [33:0] v);
        logic [16:0] r;
        logic [16:0] t;
        r = '0;
        for (int b = 16; b >= 0; b--) begin
            t = r | (17'h00001 << b);
            if ({17'h00000, t} * {17'h00000, t} <= v) begin
                r = t;
            end
        end
        isqrt = (r > 17'h0ffff) ? 16'hffff : r[15:0];
    endfunction : isqrt

    function automatic logic [21:0] sq11(input logic [11:0] v);
        sq11 = 22'(v) * 22'(v);
    endfunction : sq11
    function automatic logic [11:0] lim_lo(input logic [10:0] v);
        lim_lo = 12'(v) - 12'((int'(v) * HYST_NUM) >>> HYST_SHIFT);
    endfunction : lim_lo
    function automatic logic [11:0] lim_hi(input logic [10:0] v);
        lim_hi = 12'(v) + 12'((int'(v) * HYST_NUM) >>> HYST_SHIFT);
    endfunction : lim_hi
    function automatic logic [10:0] clamp_lim(input logic [31:0] v);
        clamp_lim = (v[15:0] > 16'(LIM_MAX)) ? LIM_MAX : v[10:0];
    endfunction : clamp_lim

    // ****************************************
    // breaker position source
    // ****************************************
    always_comb begin
        brk_closed = 1'b1;
        if (st_r.src != SRC_NONE && st_r.src < SRC_OBJ_FIRST) begin
            brk_closed = st_r.di_s2[3'(st_r.src - 5'h01)];
        end else if (st_r.src >= SRC_OBJ_FIRST && st_r.src <= SRC_LAST) begin
            brk_closed = obj_closed[3'(st_r.src - SRC_OBJ_FIRST)];
        end
    end

    // index 0 neg-seq voltage, 1 neg-seq current, 2 pos-seq voltage, 3 pos-seq current
    assign cond[0] = st_r.pick[0] & st_r.pick[1];
    assign cond[1] = st_r.pick[3] & st_r.pick[2] & brk_closed;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic        acc;
        logic [31:0] tgt;
        logic        any_done;
        acc      = 1'b0;
        tgt      = '0;
        any_done = 1'b0;
        st_nxt   = st_r;
        st_nxt.ev_on  = 1'b0;
        st_nxt.ev_off = 1'b0;

        // bus slave: address phase then write data phase
        acc            = hsel & htrans[1] & hready;
        st_nxt.wr_pend = acc & hwrite;
        st_nxt.wa      = haddr[7:0];
        if (acc && !hwrite) begin
            st_nxt.rd_mem = (haddr[7:0] >= OFS_REC_BASE) && (haddr[7:0] < OFS_REC_BASE + 8'h10);
            unique case (haddr[7:0])
                OFS_CTRL:     st_nxt.rdata = 32'({st_r.src, 1'b0, st_r.off_en, st_r.on_en, 1'b0});
                OFS_NSV_LIM:  st_nxt.rdata = 32'(st_r.lim_nsv);
                OFS_NSC_LIM:  st_nxt.rdata = 32'(st_r.lim_nsc);
                OFS_PSC_LIM:  st_nxt.rdata = 32'(st_r.lim_psc);
                OFS_DELAY:    st_nxt.rdata = 32'(st_r.dly);
                OFS_STATUS:   st_nxt.rdata = 32'({st_r.off_seen, st_r.on_seen, brk_closed,
                                                  st_r.tst[1] == TMR_ALARM, st_r.tst[0] == TMR_ALARM,
                                                  st_r.alarm});
                OFS_LIVE_NEG: st_nxt.rdata = {st_r.mag[1], st_r.mag[0]};
                OFS_LIVE_POS: st_nxt.rdata = {st_r.mag[3], st_r.mag[2]};
                default:      st_nxt.rdata = '0;
            endcase
        end else if (st_r.rd_mem) begin
            st_nxt.rd_mem = 1'b0;
            st_nxt.rdata  = mem_q;
        end
        if (st_r.wr_pend) begin
            unique case (st_r.wa)
                OFS_CTRL: begin
                    st_nxt.on_en  = hwdata[CTRL_ON_BIT];
                    st_nxt.off_en = hwdata[CTRL_OFF_BIT];
                    st_nxt.src    = (hwdata[CTRL_SRC_LSB +: 5] > SRC_LAST) ? SRC_NONE
                                                                           : hwdata[CTRL_SRC_LSB +: 5];
                end
                OFS_NSV_LIM: st_nxt.lim_nsv = clamp_lim(hwdata);
                OFS_NSC_LIM: st_nxt.lim_nsc = clamp_lim(hwdata);
                OFS_PSC_LIM: st_nxt.lim_psc = clamp_lim(hwdata);
                OFS_DELAY: begin
                    // shorter than two steps would undercut the least operate time
                    if (hwdata[15:0] < 16'(DLY_MIN_STEPS)) begin
                        st_nxt.dly = 15'(DLY_MIN_STEPS);
                    end else if (hwdata[15:0] > 16'(DLY_MAX_STEPS)) begin
                        st_nxt.dly = 15'(DLY_MAX_STEPS);
                    end else begin
                        st_nxt.dly = hwdata[14:0];
                    end
                end
                default: ;
            endcase
        end

        // pins are asynchronous to the clock
        st_nxt.di_s1 = di_pins;
        st_nxt.di_s2 = st_r.di_s1;

        // new measurement set
        if (meas_valid) begin
            st_nxt.sq[0] = seq_sq(uab_re, uab_im, ubc_re, ubc_im, uca_re, uca_im, 1'b1);
            st_nxt.sq[1] = seq_sq(ia_re, ia_im, ib_re, ib_im, ic_re, ic_im, 1'b1);
            st_nxt.sq[2] = seq_sq(uab_re, uab_im, ubc_re, ubc_im, uca_re, uca_im, 1'b0);
            st_nxt.sq[3] = seq_sq(ia_re, ia_im, ib_re, ib_im, ic_re, ic_im, 1'b0);
        end
        for (int q = 0; q < 4; q++) begin
            st_nxt.mag[q] = isqrt(st_r.sq[q]);
        end

        // squared compares are exact, so only the 0.1 percent quantum limits accuracy
        st_nxt.pick[0] = st_r.pick[0] ? (st_r.sq[0] > 34'(sq11(lim_lo(st_r.lim_nsv))))
                                      : (st_r.sq[0] > 34'(sq11(12'(st_r.lim_nsv))));
        st_nxt.pick[1] = st_r.pick[1] ? (st_r.sq[1] < 34'(sq11(lim_hi(st_r.lim_nsc))))
                                      : (st_r.sq[1] < 34'(sq11(12'(st_r.lim_nsc))));
        st_nxt.pick[2] = st_r.pick[2] ? (st_r.sq[2] < 34'(sq11(lim_hi(PSV_LOW_LIM))))
                                      : (st_r.sq[2] < 34'(sq11(12'(PSV_LOW_LIM))));
        st_nxt.pick[3] = st_r.pick[3] ? (st_r.sq[3] > 34'(sq11(lim_lo(st_r.lim_psc))))
                                      : (st_r.sq[3] > 34'(sq11(12'(st_r.lim_psc))));

        // millisecond timebase; tick phase costs at most 1 ms of delay error
        st_nxt.ms_tick = 1'b0;
        if (st_r.ms_cnt == 16'(MS_CYC - 1)) begin
            st_nxt.ms_cnt  = '0;
            st_nxt.ms_tick = 1'b1;
        end else begin
            st_nxt.ms_cnt = st_r.ms_cnt + 16'h0001;
        end

        // one definite-time timer per condition
        tgt = 32'(st_r.dly) * DLY_STEP_MS;
        for (int c = 0; c < 2; c++) begin
            unique case (st_r.tst[c])
                TMR_IDLE: begin
                    st_nxt.tcnt[c] = '0;
                    if (cond[c]) begin
                        st_nxt.tst[c] = TMR_TIMING;
                    end
                end
                TMR_TIMING: begin
                    if (!cond[c]) begin
                        st_nxt.tst[c]  = TMR_IDLE;
                        st_nxt.tcnt[c] = '0;
                    end else if (st_r.ms_tick) begin
                        if (32'(st_r.tcnt[c]) + 32'h1 >= tgt) begin
                            st_nxt.tst[c] = TMR_ALARM;
                        end else begin
                            st_nxt.tcnt[c] = st_r.tcnt[c] + 20'h00001;
                        end
                    end
                end
                TMR_ALARM: begin
                    if (!cond[c]) begin
                        st_nxt.tst[c]  = TMR_IDLE;
                        st_nxt.tcnt[c] = '0;
                    end
                end
                default: begin
                    st_nxt.tst[c]  = TMR_IDLE;
                    st_nxt.tcnt[c] = '0;
                end
            endcase
        end

        any_done     = (st_r.tst[0] == TMR_ALARM) | (st_r.tst[1] == TMR_ALARM);
        st_nxt.alarm = any_done;
        if (any_done && !st_r.alarm) begin
            st_nxt.ev_on = st_r.on_en;
        end
        if (!any_done && st_r.alarm) begin
            st_nxt.ev_off = st_r.off_en;
        end

        // sticky event flags: a new event beats a write-one clear
        st_nxt.on_seen  = st_r.ev_on | (st_r.on_seen &
                          ~(st_r.wr_pend && st_r.wa == OFS_STATUS && hwdata[ST_ONSEEN_BIT]));
        st_nxt.off_seen = st_r.ev_off | (st_r.off_seen &
                          ~(st_r.wr_pend && st_r.wa == OFS_STATUS && hwdata[ST_OFSEEN_BIT]));
    end

    assign rec_we = st_nxt.alarm & ~st_r.alarm;

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_r         <= '0;
            st_r.on_en   <= 1'b1;
            st_r.off_en  <= 1'b1;
            st_r.lim_nsv <= LIM_NSV_RST;
            st_r.lim_nsc <= LIM_NSC_RST;
            st_r.lim_psc <= LIM_PSC_RST;
            st_r.dly     <= DLY_RST;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // alarm record
    // ****************************************
    vts_rec_mem #(
        .WORDS (4),
        .AW    (2)
    ) u_rec (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ce      (ce),
        .we_all  (rec_we),
        .wdata   ({st_r.mag[3], st_r.mag[2], st_r.mag[1], st_r.mag[0],
                   16'h0000, rtc_time[47:32], rtc_time[31:0]}),
        .raddr   (haddr[3:2]),
        .rdata   (mem_q)
    );

    // ****************************************
    // outputs
    // ****************************************
    // while frozen the bus is stalled rather than answered with stale data
    assign hreadyout       = ce;
    assign hresp           = 1'b0;
    assign hrdata          = st_r.rd_mem ? mem_q : st_r.rdata;
    assign alarm           = st_r.alarm;
    assign neg_alarm       = st_r.tst[0] == TMR_ALARM;
    assign pos_alarm       = st_r.tst[1] == TMR_ALARM;
    assign volt_prot_block = st_r.alarm;
    assign evt_alarm_on    = st_r.ev_on;
    assign evt_alarm_off   = st_r.ev_off;

endmodule : vts_fuse_fail

// [shared/vts_pkg.sv]
package vts_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int unsigned CLK_HZ        = 40_000_000;
    localparam int unsigned MS_PER_S      = 1000;
    localparam int unsigned MS_CYCLES     = CLK_HZ / MS_PER_S;
    localparam int unsigned DLY_STEP_MS   = 20;
    localparam int unsigned DLY_MIN_STEPS = 2;
    localparam int unsigned DLY_MAX_STEPS = 30000;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_NSV_LIM  = 8'h04;
    localparam logic [7:0] OFS_NSC_LIM  = 8'h08;
    localparam logic [7:0] OFS_PSC_LIM  = 8'h0c;
    localparam logic [7:0] OFS_DELAY    = 8'h10;
    localparam logic [7:0] OFS_STATUS   = 8'h14;
    localparam logic [7:0] OFS_LIVE_NEG = 8'h18;
    localparam logic [7:0] OFS_LIVE_POS = 8'h1c;
    localparam logic [7:0] OFS_REC_BASE = 8'h20;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int unsigned CTRL_ON_BIT   = 1;
    localparam int unsigned CTRL_OFF_BIT  = 2;
    localparam int unsigned CTRL_SRC_LSB  = 4;
    localparam int unsigned ST_ONSEEN_BIT = 4;
    localparam int unsigned ST_OFSEEN_BIT = 5;
    localparam logic [10:0] LIM_NSV_RST   = 11'h15a;
    localparam logic [10:0] LIM_NSC_RST   = 11'h3e8;
    localparam logic [10:0] LIM_PSC_RST   = 11'h3e8;
    localparam logic [10:0] LIM_MAX       = 11'h7d0;
    localparam logic [10:0] PSV_LOW_LIM   = 11'h00a;
    localparam logic [14:0] DLY_RST       = 15'h0005;
    localparam logic [4:0]  SRC_NONE      = 5'h00;
    localparam logic [4:0]  SRC_OBJ_FIRST = 5'h09;
    localparam logic [4:0]  SRC_LAST      = 5'h10;

    // ****************************************
    // arithmetic constants
    // ****************************************
    localparam int HYST_NUM   = 123;
    localparam int HYST_SHIFT = 12;
    localparam int ROT_K      = 887;
    localparam int ROT_SHIFT  = 10;

    typedef enum logic [1:0] {
        TMR_IDLE   = 2'b00,
        TMR_TIMING = 2'b01,
        TMR_ALARM  = 2'b11
    } vts_tmr_e;

endpackage : vts_pkg

// [verilog/vts_rec_mem.sv]
`timescale 1ns/1ps
module vts_rec_mem import vts_pkg::*; #(
    parameter int unsigned WORDS = 4,
    parameter int unsigned AW    = 2
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire logic                  ce,
    input  wire logic                  we_all,
    input  wire logic [WORDS*32-1:0]   wdata,
    input  wire logic [AW-1:0]         raddr,
    output logic      [31:0]           rdata
);

    // ****************************************
    // alarm record store
    // ****************************************
    typedef struct packed {
        logic [WORDS-1:0][31:0] mem;
        logic [31:0]            q;
    } vts_mem_s;

    vts_mem_s st_r;
    vts_mem_s st_nxt;

    always_comb begin
        st_nxt   = st_r;
        st_nxt.q = st_r.mem[raddr];
        if (we_all) begin
            st_nxt.mem = wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.q;

endmodule : vts_rec_mem

// [test/vts_meas_model.sv]
`timescale 1ns/1ps
module vts_meas_model (
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic [1:0]   mode,
    input  wire logic [15:0]  mag,
    output logic              meas_valid,
    output logic [11:0][15:0] ph
);
    // ********
    // phasor source, one set per 40 cycles
    // ********
    logic [5:0]        cnt_r;
    logic [11:0][15:0] val;
    int                h, s, k;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r      <= 6'h00;
            meas_valid <= 1'b0;
        end else begin
            cnt_r      <= (cnt_r == 6'h27) ? 6'h00 : cnt_r + 6'h01;
            meas_valid <= (cnt_r == 6'h27);
        end
    end
    always_comb begin
        h       = int'(mag) / 2;
        s       = int'(mag) * 866 / 1000;
        k       = (mode == 2'h0) ? 1 : 0;
        val[0]  = (mode == 2'h2) ? 16'hbb8 : 16'(1000 * k);
        val[1]  = 16'h0000;
        val[2]  = 16'(-500 * k);
        val[3]  = 16'(-866 * k);
        val[4]  = 16'(-500 * k);
        val[5]  = 16'(866 * k);
        val[6]  = mag;
        val[7]  = 16'h0000;
        val[8]  = 16'(-h);
        val[9]  = 16'(-s);
        val[10] = 16'(-h);
        val[11] = 16'(s);
    end
    // lines show the inverse off the valid cycle, so a late sample is caught
    assign ph = meas_valid ? val : ~val;
endmodule : vts_meas_model

// [test/vts_fuse_fail_asserts.sv]
`timescale 1ns/1ps
module vts_chk (
    input logic        clk_sys,
    input logic        rst_n,
    input logic        ce,
    input logic        hsel,
    input logic [1:0]  htrans,
    input logic        hwrite,
    input logic        hready,
    input logic        hreadyout,
    input logic        hresp,
    input logic [31:0] hrdata,
    input logic        alarm,
    input logic        neg_alarm,
    input logic        pos_alarm,
    input logic        volt_prot_block,
    input logic        evt_alarm_on,
    input logic        evt_alarm_off
);
    // ********
    // port relations
    // ********
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_rise;
        !alarm ##1 alarm;
    endsequence
    a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
    a_ready_ce: assert property (hreadyout == ce) else $error("ready differs from enable");
    a_block_follows: assert property (volt_prot_block == alarm) else $error("block differs");
    a_rise_cause: assert property (s_rise |-> neg_alarm || pos_alarm) else $error("no cause");
    a_on_edge: assert property (evt_alarm_on |-> $rose(alarm)) else $error("raise event off edge");
    a_off_edge: assert property (evt_alarm_off |-> $fell(alarm)) else $error("clear event off edge");
    a_on_single: assert property (evt_alarm_on |=> !evt_alarm_on) else $error("event too long");
    a_rdata_hold: assert property (!(hsel && htrans[1] && hready && ce && !hwrite) |=> $stable(hrdata))
        else $error("read data moved");
    a_ce_freeze: assert property (!ce |=> $stable(alarm) && $stable(hrdata)) else $error("not frozen");
endmodule : vts_chk
bind vts_fuse_fail vts_chk vts_chk_i (.clk_sys, .rst_n, .ce, .hsel, .htrans, .hwrite, .hready, .hreadyout,
    .hresp, .hrdata, .alarm, .neg_alarm, .pos_alarm, .volt_prot_block, .evt_alarm_on, .evt_alarm_off);

// [test/vts_fuse_fail_bench.sv]
`timescale 1ns/1ps
module vts_fuse_fail_bench import vts_pkg::*; ();
    // ********
    // bench
    // ********
    localparam int MS = 40; // short ms keeps the minimum delay at 1600 cycles
    logic              clk_sys, rst_n, ce, hsel, hwrite, hreadyout, hresp, meas_valid;
    logic              alarm, neg_al, pos_al, blk, ev_on, ev_off;
    logic [31:0]       haddr, hwdata, hrdata, q;
    logic [1:0]        htrans, mode;
    logic [2:0]        hsize;
    logic [47:0]       rtc;
    logic [7:0]        di, obj;
    logic [15:0]       mag;
    logic [11:0][15:0] ph;
    logic [7:0]        ra [5] = '{OFS_CTRL, OFS_NSV_LIM, OFS_NSC_LIM, OFS_PSC_LIM, OFS_DELAY};
    logic [31:0]       rv [5] = '{32'h6, 32'h15a, 32'h3e8, 32'h3e8, 32'h5};
    int                err_count, compares, cyc, n_on, n_off, seed, d, src;
    initial begin
        clk_sys = 0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    vts_fuse_fail #(.MS_CYC(MS)) vts_fuse_fail_i (.clk_sys, .rst_n, .ce, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .meas_valid, .uab_re(ph[0]),
        .uab_im(ph[1]), .ubc_re(ph[2]), .ubc_im(ph[3]), .uca_re(ph[4]), .uca_im(ph[5]), .ia_re(ph[6]),
        .ia_im(ph[7]), .ib_re(ph[8]), .ib_im(ph[9]), .ic_re(ph[10]), .ic_im(ph[11]), .rtc_time(rtc),
        .di_pins(di), .obj_closed(obj), .alarm, .neg_alarm(neg_al), .pos_alarm(pos_al),
        .volt_prot_block(blk), .evt_alarm_on(ev_on), .evt_alarm_off(ev_off));
    vts_meas_model vts_meas_model_i (.clk_sys, .rst_n, .mode, .mag, .meas_valid, .ph);
    always @(posedge clk_sys) begin
        cyc++;
        n_on += (ev_on === 1'b1);
        n_off += (ev_off === 1'b1);
        if (cyc == 30000) begin
            err_count++;
            stop_test;
        end
    end
    task stop_test;
        $display("compares %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stop_test
    task chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            err_count++;
            $display("wrong value at %0t: seen %h, expected %h", $time, s, e);
        end
    endtask : chk
    // master waits on ready with no cycle count assumed; the cycle ceiling ends a hang
    task bus(input logic w, input logic [7:0] a, input logic [31:0] dt);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        htrans <= 2'h0;
        hwdata <= dt;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        q = hrdata;
    endtask : bus
    task rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rd
    task wt(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : wt
    function int dly(input int steps);
        return steps * DLY_STEP_MS * MS;
    endfunction : dly
    initial begin
        seed = 45;
        {rst_n, hsel, hwrite, htrans, haddr, hwdata, mode, rtc, di, obj} = '0;
        ce = 1'b1;
        hsize = 3'h2;
        mag = 16'h1f4;
        wt(2);
        rst_n <= 1'b1;
        wt(1);
        for (int i = 0; i < 5; i++) rd(ra[i], rv[i]);
        bus(1'b1, OFS_DELAY, 32'h0);
        rd(OFS_DELAY, 32'h2);
        bus(1'b1, OFS_NSV_LIM, 32'hbb8);
        rd(OFS_NSV_LIM, 32'h7d0);
        bus(1'b1, OFS_NSV_LIM, 32'h15a);
        bus(1'b1, 8'h40, 32'h5a);
        rd(8'h40, 32'h0);
        ce <= 1'b0;
        fork
            begin wt(3); ce <= 1'b1; end
            rd(OFS_DELAY, 32'h2);
        join
        $display("test registers done");
        d = dly(2);
        rtc <= {16'($random(seed)), 32'($random(seed))};
        mag <= 16'(1100 + $unsigned($random(seed)) % 800);
        mode <= 2'h1;
        wt(d - 80);
        chk(alarm, 0);
        wt(200);
        chk({alarm, pos_al}, 2'h3);
        rd(OFS_STATUS, 32'h1d);
        rd(8'h20, rtc[31:0]);
        rd(8'h24, {16'h0, rtc[47:32]});
        bus(1'b0, 8'h2c, 32'h0);
        chk(q[15:0], 0);
        bus(1'b0, OFS_LIVE_POS, 32'h0);
        chk(q[15:0], 0);
        mode <= 2'h0;
        wt(60 * MS);
        chk(alarm, 0);
        rd(OFS_STATUS, 32'h38);
        bus(1'b1, OFS_STATUS, 32'h30);
        rd(OFS_STATUS, 32'h8);
        $display("test positive sequence done");
        mode <= 2'h1;
        wt(d / 2);
        mode <= 2'h0;
        wt(200);
        mode <= 2'h1;
        wt(d - 80);
        chk(alarm, 0);
        wt(200);
        chk(alarm, 1);
        mode <= 2'h2;
        mag <= 16'h1f4;
        wt(80);
        chk(alarm, 0);
        wt(d - 160);
        chk(alarm, 0);
        wt(200);
        chk({alarm, neg_al}, 2'h3);
        rd(8'h28, 32'h3e8);
        rd(OFS_LIVE_NEG, 32'h3e8);
        mode <= 2'h0;
        wt(60 * MS);
        $display("test lapse and negative sequence done");
        bus(1'b1, OFS_STATUS, 32'h30);
        src = 1 + $unsigned($random(seed)) % 16;
        bus(1'b1, OFS_CTRL, 32'(src) << 4);
        rd(OFS_CTRL, 32'(src) << 4);
        mode <= 2'h1;
        mag <= 16'h5dc;
        wt(d + 120);
        chk(alarm, 0);
        if (src < 9) di <= 8'h1 << (src - 1);
        else obj <= 8'h1 << (src - 9);
        wt(d + 120);
        chk(alarm, 1);
        rd(OFS_STATUS, 32'hd);
        mode <= 2'h0;
        wt(60 * MS);
        chk(n_on, 3);
        chk(n_off, 3);
        bus(1'b1, OFS_CTRL, 32'h110);
        rd(OFS_CTRL, 32'h0);
        $display("test breaker qualification done");
        stop_test;
    end
endmodule : vts_fuse_fail_bench
